/* hdl/psl_ctrl.sv */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module psl_ctrl #(
    parameter int unsigned SAVE_CYC = psl_pkg::SAVE_CYCLES,
    parameter int unsigned UNLOCK_CYC = psl_pkg::UNLOCK_CYCLES
) (
    // clock and resets
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nvm_rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pin and neighbouring logic inputs
    input wire logic vpp_ok_pin,
    input wire logic motor_running,
    input wire logic lp_wake,
    input wire logic [9:0] speed_voltage_input,
    input wire psl_pkg::psl_crit_t crit_set,
    input wire psl_pkg::psl_fault_t fault_set,
    // motor side outputs
    output logic coast_q,
    output logic save_busy_q,
    output logic locked_q,
    output logic reg_speed_en_q,
    output logic [9:0] speed_ref_q,
    output logic [9:0] run_q,
    output logic fault_output_pin_n_q
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------

    // write count after a good save, wraps once then saturates
    function automatic logic [10:0] next_count(input logic [9:0] cnt, input logic worn);
        logic [10:0] r;
        r = {worn, cnt + 10'h001};
        if (cnt == psl_pkg::COUNT_MAX) begin
            r = worn ? {1'b1, psl_pkg::COUNT_MAX} : {1'b1, 10'h000};
        end
        return r;
    endfunction : next_count

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    psl_pkg::psl_state_t state_q;
    psl_pkg::psl_state_t state_d;
    logic [4:0] idx_q;
    logic [31:0] tmr_q;
    logic [31:0] ul_tmr_q;
    logic ul_run_q;
    logic pw_ok_q;
    logic fail_lat_q;
    logic mem_ok_q;
    logic save_trig_q;
    logic [9:0] mask_q;
    logic [9:0] fault_output_pin_q;
    logic [9:0] cfg_speed_q;
    logic [9:0] nvm_code_q;
    logic [9:0] wcc_q;
    logic wear_q;
    psl_pkg::psl_crit_t crit_q;
    psl_pkg::psl_fault_t fault_q;
    logic [15:0] lfsr_q;
    logic [2:0] vpp_s_q;
    logic vpp_ok_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire logic [4:0] a_idx = paddr[6:2];
    wire logic a_cfg = a_idx <= psl_pkg::IDX_CFG_LAST;
    wire logic a_in_map = ~paddr[7] & (a_cfg | a_idx >= psl_pkg::IDX_CTRL);
    wire logic acc = psel & penable & ~pready;
    wire logic busy = state_q != psl_pkg::ST_IDLE;
    wire logic eff_lock = locked_q & ~pw_ok_q;
    wire logic needs_mem = a_cfg & a_in_map;
    wire logic wr_full = pstrb[1:0] == 2'b11;
    wire logic mem_issue = acc & needs_mem & ~busy & ~mem_ok_q;
    wire logic go = acc & (~needs_mem | mem_ok_q);
    wire logic wr_ok = go & pwrite & wr_full & a_in_map & ~eff_lock;
    wire logic [9:0] wdat = pwdata[9:0];

    // ----------------------------------------------------------------
    // save, load and clear sequencing
    // ----------------------------------------------------------------
    wire logic save_start = wr_ok & (a_idx == psl_pkg::IDX_CTRL) & save_trig_q
        & ~wdat[psl_pkg::SAVE_BIT] & ~busy;
    wire logic in_save = state_q == psl_pkg::ST_SAVE_RD | state_q == psl_pkg::ST_SAVE_WR
        | state_q == psl_pkg::ST_SAVE_WAIT;
    wire logic tmr_done = tmr_q >= SAVE_CYC - 32'd1;
    wire logic save_end = state_q == psl_pkg::ST_SAVE_WAIT & tmr_done;
    wire logic save_ok = save_end & ~fail_lat_q & vpp_ok_q;
    wire logic save_fail = save_end & ~save_ok;
    wire logic ul_done = ul_run_q & (ul_tmr_q >= UNLOCK_CYC - 32'd1);
    wire logic last_idx = idx_q == psl_pkg::IDX_CFG_LAST;
    wire logic [10:0] cnt_next = next_count(wcc_q, wear_q);

    // next state of the sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            psl_pkg::ST_IDLE: state_d = save_start ? psl_pkg::ST_SAVE_RD :
                ul_done ? psl_pkg::ST_CLEAR : psl_pkg::ST_IDLE;
            psl_pkg::ST_LOAD_RD: state_d = psl_pkg::ST_LOAD_WR;
            psl_pkg::ST_LOAD_WR: state_d = last_idx ? psl_pkg::ST_IDLE : psl_pkg::ST_LOAD_RD;
            psl_pkg::ST_SAVE_RD: state_d = psl_pkg::ST_SAVE_WR;
            psl_pkg::ST_SAVE_WR: state_d = last_idx ? psl_pkg::ST_SAVE_WAIT : psl_pkg::ST_SAVE_RD;
            psl_pkg::ST_SAVE_WAIT: state_d = tmr_done ? psl_pkg::ST_IDLE : psl_pkg::ST_SAVE_WAIT;
            psl_pkg::ST_CLEAR: state_d = psl_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // memory ports: live registers and nonvolatile store
    // ----------------------------------------------------------------
    logic [9:0] sh_rdata;
    logic [9:0] nvm_rdata;
    wire logic sh_re = busy ? state_q == psl_pkg::ST_SAVE_RD : mem_issue & ~pwrite;
    wire logic sh_apb_we = mem_issue & pwrite & wr_full & ~eff_lock;
    wire logic sh_we = busy ? state_q == psl_pkg::ST_LOAD_WR : sh_apb_we;
    wire logic [4:0] sh_addr = busy ? idx_q : a_idx;
    wire logic [9:0] sh_wdata = busy ? nvm_rdata : wdat;
    wire logic nvm_clr = state_q == psl_pkg::ST_CLEAR;
    wire logic nvm_re = state_q == psl_pkg::ST_LOAD_RD;
    wire logic nvm_we = state_q == psl_pkg::ST_SAVE_WR | nvm_clr;
    wire logic [4:0] nvm_addr = nvm_clr ? psl_pkg::IDX_LOCK : idx_q;
    wire logic [9:0] nvm_wdata = nvm_clr ? 10'h000 : sh_rdata;

    // live register set
    psl_mem #(.W(psl_pkg::DATA_W), .D(psl_pkg::NUM_REGS), .AW(psl_pkg::IDX_W)) u_live (
        .clk(pclk), .rst_n(presetn), .addr(sh_addr), .re(sh_re),
        .we(sh_we), .wdata(sh_wdata), .rdata_q(sh_rdata)
    );

    // nonvolatile store, survives presetn
    psl_mem #(.W(psl_pkg::DATA_W), .D(psl_pkg::NUM_REGS), .AW(psl_pkg::IDX_W)) u_store (
        .clk(pclk), .rst_n(nvm_rst_n), .addr(nvm_addr), .re(nvm_re),
        .we(nvm_we), .wdata(nvm_wdata), .rdata_q(nvm_rdata)
    );

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire logic a_open = a_idx == psl_pkg::IDX_CTRL | a_idx == psl_pkg::IDX_FAULT_OUTPUT_PIN;
    wire logic [9:0] body_raw = ~a_in_map ? 10'h000 : a_cfg ? sh_rdata :
        a_idx == psl_pkg::IDX_CTRL ? wcc_q : a_idx == psl_pkg::IDX_MASK ? mask_q :
        a_idx == psl_pkg::IDX_FAULT_OUTPUT_PIN ? {fault_q, 3'b000} : run_q;
    wire logic [9:0] part_keep = a_idx == psl_pkg::IDX_PART ? psl_pkg::PART_MASK : 10'h000;
    wire logic [9:0] body_lock = (body_raw & part_keep) | (lfsr_q[9:0] & ~part_keep);
    wire logic [9:0] body = eff_lock & ~a_open ? body_lock : body_raw;
    wire logic [15:0] rd_word = {crit_q, body};

    // apb answer, one wait cycle, or two for the register set plus the rest of any running load or save
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            mem_ok_q <= 1'b0;
        end else begin
            pready <= go;
            pslverr <= go & ~a_in_map;
            mem_ok_q <= mem_issue | (mem_ok_q & ~go);
            if (go & ~pwrite) begin
                prdata <= {16'h0000, rd_word};
            end
        end
    end

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= psl_pkg::ST_LOAD_RD;
            idx_q <= 5'h00;
            tmr_q <= 32'h0000_0000;
            fail_lat_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == psl_pkg::ST_LOAD_WR | state_q == psl_pkg::ST_SAVE_WR) begin
                idx_q <= last_idx ? 5'h00 : idx_q + 5'h01;
            end
            if (save_start) begin
                tmr_q <= 32'h0000_0000;
                fail_lat_q <= 1'b0;
            end else if (in_save) begin
                tmr_q <= tmr_q + 32'h0000_0001;
                fail_lat_q <= fail_lat_q | ~vpp_ok_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers written by software
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            save_trig_q <= 1'b0;
            mask_q <= psl_pkg::REG_RST;
            fault_output_pin_q <= psl_pkg::REG_RST;
            run_q <= psl_pkg::REG_RST;
        end else if (wr_ok) begin
            if (a_idx == psl_pkg::IDX_CTRL) begin
                save_trig_q <= wdat[psl_pkg::SAVE_BIT];
            end
            if (a_idx == psl_pkg::IDX_MASK) begin
                mask_q <= wdat & psl_pkg::MASK_WR_MASK;
            end
            if (a_idx == psl_pkg::IDX_FAULT_OUTPUT_PIN) begin
                fault_output_pin_q <= wdat & psl_pkg::FAULT_OUTPUT_PIN_WR_MASK;
            end
            if (a_idx == psl_pkg::IDX_RUN & ~save_busy_q) begin
                run_q <= wdat;
            end
        end
    end

    // ----------------------------------------------------------------
    // lock state and code handling
    // ----------------------------------------------------------------
    wire logic code_try = go & pwrite & wr_full & locked_q & (a_idx == psl_pkg::IDX_LOCK);
    wire logic code_match = code_try & (wdat == nvm_code_q) & ~ul_run_q;
    wire logic load_end = state_q == psl_pkg::ST_LOAD_WR & last_idx;

    // lock mode, unlock timer, mirror of stored code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_q <= 1'b0;
            pw_ok_q <= 1'b0;
            ul_run_q <= 1'b0;
            ul_tmr_q <= 32'h0000_0000;
            nvm_code_q <= psl_pkg::REG_RST;
        end else begin
            if (state_q == psl_pkg::ST_LOAD_WR & idx_q == psl_pkg::IDX_LOCK) begin
                nvm_code_q <= nvm_rdata;
            end else if (state_q == psl_pkg::ST_SAVE_WR & idx_q == psl_pkg::IDX_LOCK) begin
                nvm_code_q <= sh_rdata;
            end else if (nvm_clr) begin
                nvm_code_q <= 10'h000;
            end
            if (load_end | (lp_wake & ~busy)) begin
                locked_q <= nvm_code_q != 10'h000;
                pw_ok_q <= 1'b0;
            end
            if (code_match) begin
                pw_ok_q <= 1'b1;
                ul_run_q <= 1'b1;
                ul_tmr_q <= 32'h0000_0000;
            end else if (ul_done & ~busy) begin
                ul_run_q <= 1'b0;
            end else if (ul_run_q & ~ul_done) begin
                ul_tmr_q <= ul_tmr_q + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // write count and flags
    // ----------------------------------------------------------------
    // count and wear flag sit with the store, so a power cycle keeps them
    always_ff @(posedge pclk or negedge nvm_rst_n) begin
        if (!nvm_rst_n) begin
            wcc_q <= psl_pkg::REG_RST;
            wear_q <= 1'b0;
        end else if (save_ok) begin
            wcc_q <= cnt_next[9:0];
            wear_q <= cnt_next[10];
        end
    end

    // sticky fault flags, cleared by a good save; ee follows the wear flag instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crit_q <= '0;
            fault_q <= '0;
        end else begin
            crit_q.ee <= wear_q;
            // set wins over the clear of a good save
            crit_q[5:1] <= crit_set[5:1] | {save_fail, 4'h0} | (crit_q[5:1] & ~{5{save_ok}});
            fault_q <= fault_set | (fault_q & ~{7{save_ok}});
        end
    end

    // ----------------------------------------------------------------
    // motor side outputs
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coast_q <= 1'b0;
            save_busy_q <= 1'b0;
            reg_speed_en_q <= 1'b0;
            speed_ref_q <= psl_pkg::REG_RST;
            cfg_speed_q <= psl_pkg::REG_RST;
            fault_output_pin_n_q <= 1'b1;
        end else begin
            if (save_start) begin
                coast_q <= motor_running;
                save_busy_q <= 1'b1;
            end else if (save_end) begin
                coast_q <= 1'b0;
                save_busy_q <= 1'b0;
            end
            if (sh_we & sh_addr == psl_pkg::IDX_SPEED) begin
                cfg_speed_q <= sh_wdata;
            end
            reg_speed_en_q <= ~eff_lock;
            if (~save_busy_q) begin
                // analog input alone when locked, register value may override when open
                speed_ref_q <= (~eff_lock & cfg_speed_q != 10'h000) ?
                    cfg_speed_q : speed_voltage_input;
            end
            fault_output_pin_n_q <= ~(|crit_q[5:1]);
        end
    end

    // ----------------------------------------------------------------
    // random source and programming supply sampling
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_q <= psl_pkg::LFSR_SEED;
            vpp_s_q <= 3'b000;
            vpp_ok_q <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & psl_pkg::LFSR_TAPS)};
            vpp_s_q <= {vpp_s_q[1:0], vpp_ok_pin};
            if (vpp_s_q[1] == vpp_s_q[2]) begin
                vpp_ok_q <= vpp_s_q[2];
            end
        end
    end

endmodule : psl_ctrl

/* hdl/psl_mem.sv */
`timescale 1ns/1ps
module psl_mem #(
    parameter int W = 10,
    parameter int D = 32,
    parameter int AW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access port
    input wire logic [AW-1:0] addr,
    input wire logic re,
    input wire logic we,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata_q
);

    logic [W-1:0] mem_q [D];

    // one port, registered read data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < D; i++) begin
                mem_q[i] <= '0;
            end
            rdata_q <= '0;
        end else begin
            if (we) begin
                mem_q[addr] <= wdata;
            end
            if (re) begin
                rdata_q <= mem_q[addr];
            end
        end
    end

endmodule : psl_mem

/* hdl/psl_pkg.sv */
package psl_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned SAVE_TIME_MS = 700;
    localparam int unsigned SAVE_CYCLES = SAVE_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned UNLOCK_TIME_S = 15;
    localparam int unsigned UNLOCK_CYCLES = UNLOCK_TIME_S * CLK_HZ;

    // ----------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int DATA_W = 10;
    localparam int IDX_W = 5;
    localparam int NUM_REGS = 32;
    localparam logic [4:0] IDX_CFG_LAST = 5'h15;
    localparam logic [4:0] IDX_LOCK = 5'h0b;
    localparam logic [4:0] IDX_PART = 5'h0f;
    localparam logic [4:0] IDX_SPEED = 5'h10;
    localparam logic [4:0] IDX_CTRL = 5'h1c;
    localparam logic [4:0] IDX_MASK = 5'h1d;
    localparam logic [4:0] IDX_FAULT_OUTPUT_PIN = 5'h1e;
    localparam logic [4:0] IDX_RUN = 5'h1f;

    // ----------------------------------------------------------------
    // field layouts and reset values
    // ----------------------------------------------------------------
    localparam int SAVE_BIT = 9;
    localparam logic [9:0] PART_MASK = 10'h0f0;
    localparam logic [9:0] MASK_WR_MASK = 10'h3f8;
    localparam logic [9:0] FAULT_OUTPUT_PIN_WR_MASK = 10'h01c;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;
    localparam logic [9:0] REG_RST = 10'h000;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic ff;
        logic por;
        logic me;
        logic wd;
        logic oc;
        logic ee;
    } psl_crit_t;

    typedef struct packed {
        logic tw;
        logic ot;
        logic los;
        logic pmf;
        logic hoc;
        logic ovm;
        logic uvm;
    } psl_fault_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD_RD,
        ST_LOAD_WR,
        ST_SAVE_RD,
        ST_SAVE_WR,
        ST_SAVE_WAIT,
        ST_CLEAR
    } psl_state_t;

endpackage : psl_pkg

/* testbench/psl_ctrl_checker.sv */
`timescale 1ns/1ps
module psl_ctrl_checker #(
    parameter int unsigned SAVE_CYC = 200,
    parameter int unsigned UNLOCK_CYC = 100
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    // motor side
    input wire logic motor_running,
    input wire logic [9:0] speed_voltage_input,
    input wire logic coast_q,
    input wire logic save_busy_q,
    input wire logic locked_q,
    input wire logic reg_speed_en_q,
    input wire logic [9:0] speed_ref_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // decode and save length count
    // ------------------------------------------------------------
    wire done = psel & penable & pready;
    wire fast = (paddr[6:2] >= psl_pkg::IDX_CTRL) & ~paddr[7];
    wire bad = paddr[7] | (paddr[6:2] > psl_pkg::IDX_CFG_LAST) & (paddr[6:2] < psl_pkg::IDX_CTRL);
    wire ctl_wr = done & pwrite & (paddr == 8'h70) & (&pstrb[1:0]) & ~locked_q;
    logic sav_q;
    logic [31:0] busy_cnt_q;
    // last stored save bit, cycles spent busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sav_q <= 1'b0;
            busy_cnt_q <= 32'h0;
        end else begin
            sav_q <= ctl_wr ? pwdata[9] : sav_q;
            busy_cnt_q <= save_busy_q ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_save_start: assert property (
        ctl_wr && sav_q && !pwdata[9] && !$past(save_busy_q) |-> save_busy_q)
        else $error("save not started");
    a_coast_entry: assert property ($rose(save_busy_q) |-> coast_q == $past(motor_running))
        else $error("coast not taken");
    a_save_len: assert property (
        $fell(save_busy_q) |-> busy_cnt_q >= SAVE_CYC - 1 && busy_cnt_q <= SAVE_CYC + 1)
        else $error("save length wrong");
    a_save_bound: assert property (save_busy_q |-> busy_cnt_q <= SAVE_CYC + 1)
        else $error("save restarted");
    a_speed_hold: assert property (save_busy_q && $past(save_busy_q) |-> $stable(speed_ref_q))
        else $error("speed moved in save");
    a_lock_speed: assert property (
        locked_q && $past(locked_q) && !reg_speed_en_q && !$past(reg_speed_en_q) && !save_busy_q
        |=> reg_speed_en_q || speed_ref_q == $past(speed_voltage_input))
        else $error("locked speed not analog");
    a_fast_answer: assert property (psel && penable && !pready && fast |=> pready)
        else $error("late answer");
    a_unmapped: assert property (done && bad |-> pslverr)
        else $error("no error on unmapped");
    c_save: cover property ($rose(save_busy_q));
    c_bad: cover property (done && bad);
    c_lock: cover property ($rose(locked_q));
endmodule : psl_ctrl_checker

bind psl_ctrl psl_ctrl_checker #(.SAVE_CYC(SAVE_CYC), .UNLOCK_CYC(UNLOCK_CYC)) psl_ctrl_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .motor_running(motor_running), .speed_voltage_input(speed_voltage_input),
    .coast_q(coast_q), .save_busy_q(save_busy_q), .locked_q(locked_q),
    .reg_speed_en_q(reg_speed_en_q), .speed_ref_q(speed_ref_q)
);

/* testbench/psl_ctrl_tb_top.sv */
`timescale 1ns/1ps
module psl_ctrl_tb_top;
    localparam int SAVE = 50;
    localparam int UNLOCK = 100;
    logic pclk, presetn, nvm_rst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic vpp_ok_pin, motor_running, lp_wake, coast_q, save_busy_q, locked_q;
    logic reg_speed_en_q, fault_output_pin_n_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [9:0] speed_voltage_input, speed_ref_q, run_q, cnt;
    psl_pkg::psl_crit_t crit_set;
    psl_pkg::psl_fault_t fault_set;
    int errors, checks, cycles;

    psl_ctrl #(.SAVE_CYC(SAVE), .UNLOCK_CYC(UNLOCK)) psl_ctrl_i (
        .pclk(pclk), .presetn(presetn), .nvm_rst_n(nvm_rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .vpp_ok_pin(vpp_ok_pin),
        .motor_running(motor_running), .lp_wake(lp_wake),
        .speed_voltage_input(speed_voltage_input), .crit_set(crit_set),
        .fault_set(fault_set), .coast_q(coast_q), .save_busy_q(save_busy_q),
        .locked_q(locked_q), .reg_speed_en_q(reg_speed_en_q), .speed_ref_q(speed_ref_q),
        .run_q(run_q), .fault_output_pin_n_q(fault_output_pin_n_q));
    psl_host_model psl_host_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    always #25 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] idx, input logic [9:0] d);
        psl_host_model_i.xfer(1'b1, idx, d, 4'hf, rdat, rerr);
    endtask : wr
    task automatic rd(input logic [4:0] idx);
        psl_host_model_i.xfer(1'b0, idx, 10'h0, 4'hf, rdat, rerr);
    endtask : rd
    // save bit one then zero, optionally wait for the end
    task automatic save(input logic wait_done);
        wr(psl_pkg::IDX_CTRL, 10'h200);
        wr(psl_pkg::IDX_CTRL, 10'h000);
        while (wait_done && save_busy_q !== 1'b0) @(posedge pclk);
    endtask : save
    task automatic pwr_cycle();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(5'h00);
    endtask : pwr_cycle
    task automatic finish_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        {presetn, nvm_rst_n, motor_running, lp_wake, vpp_ok_pin} = 5'h01;
        {speed_voltage_input, crit_set, fault_set} = 23'h0;
        repeat (5) @(posedge pclk);
        {presetn, nvm_rst_n} <= 2'b11;
        rd(5'h00);
        chk(rdat[9:0], 10'h000);
        chk(locked_q, 1'b0);
        wr(5'h00, 10'h2a5);
        wr(psl_pkg::IDX_PART, 10'h0a0);
        wr(psl_pkg::IDX_SPEED, 10'h123);
        psl_host_model_i.xfer(1'b1, 5'h00, 10'h111, 4'h1, rdat, rerr);
        rd(5'h00);
        chk(rdat[9:0], 10'h2a5);
        chk(speed_ref_q, 10'h123);
        for (int i = 22; i < 28; i++) begin
            rd(i[4:0]);
            chk(rerr, 1'b1);
        end
        // fault flag then a save with the motor running and a retrigger
        fault_set <= psl_pkg::psl_fault_t'(7'h40);
        @(posedge pclk);
        fault_set <= '0;
        rd(psl_pkg::IDX_CTRL);
        cnt = rdat[9:0];
        motor_running <= 1'b1;
        save(1'b0);
        chk(coast_q, 1'b1);
        chk(save_busy_q, 1'b1);
        wr(psl_pkg::IDX_RUN, 10'h155);
        chk(run_q, 10'h000);
        speed_voltage_input <= 10'h3c3;
        save(1'b1);
        motor_running <= 1'b0;
        chk(coast_q, 1'b0);
        wr(psl_pkg::IDX_RUN, 10'h155);
        chk(run_q, 10'h155);
        rd(psl_pkg::IDX_CTRL);
        chk(rdat[9:0], cnt + 10'h1);
        rd(psl_pkg::IDX_FAULT_OUTPUT_PIN);
        chk(rdat[9:3], 7'h00);
        // wear out the count
        for (int i = int'(cnt) + 1; i < 1024; i++) save(1'b1);
        rd(psl_pkg::IDX_CTRL);
        chk(rdat[15:0], 16'h0400);
        chk(fault_output_pin_n_q, 1'b1);
        // lock, power cycle, unlock
        wr(psl_pkg::IDX_LOCK, 10'h155);
        save(1'b1);
        pwr_cycle();
        chk(locked_q, 1'b1);
        wr(5'h00, 10'h0f0);
        rd(psl_pkg::IDX_PART);
        chk(rdat[7:4], 4'ha);
        speed_voltage_input <= 10'h077;
        repeat (3) @(posedge pclk);
        chk(speed_ref_q, 10'h077);
        wr(psl_pkg::IDX_LOCK, 10'h155);
        rd(5'h00);
        chk(rdat[9:0], 10'h2a5);
        chk(reg_speed_en_q, 1'b1);
        lp_wake <= 1'b1;
        @(posedge pclk);
        lp_wake <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(reg_speed_en_q, 1'b0);
        repeat (UNLOCK + 20) @(posedge pclk);
        pwr_cycle();
        chk(locked_q, 1'b0);
        // save without programming supply
        vpp_ok_pin <= 1'b0;
        rd(psl_pkg::IDX_CTRL);
        cnt = rdat[9:0];
        chk(rdat[10:0], 11'h401);
        save(1'b1);
        vpp_ok_pin <= 1'b1;
        rd(psl_pkg::IDX_CTRL);
        chk({rdat[15], rdat[9:0]}, {1'b1, cnt});
        finish_test();
    end
endmodule : psl_ctrl_tb_top

/* testbench/psl_host_model.sv */
`timescale 1ns/1ps
module psl_host_model (
    // clock
    input wire logic pclk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // bus idle at time zero
    initial begin
        {psel, penable, pwrite} = 3'b000;
        {paddr, pwdata, pstrb} = 44'h0;
    end
    // one word transfer, held until pready
    task automatic xfer(input logic wr, input logic [4:0] idx, input logic [9:0] d,
                        input logic [3:0] strb, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {22'h0, d};
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : psl_host_model
